/* dscr_pkg.sv */
// constants and helpers for the driver supply configuration register block
package dscr_pkg;

  // ************************************************************
  // bus geometry and map
  // ************************************************************
  localparam int          ADR_W       = 12;
  localparam logic [7:0]  CFG_IDX     = 8'hAE;
  localparam logic [11:0] CFG_ADDR    = {2'h0, CFG_IDX, 2'h0};
  localparam logic [31:0] CFG_RESET   = 32'h00000000;
  localparam logic [31:0] CFG_WMASK   = 32'h81FE0000;
  localparam logic [31:0] UNMAP_DATA  = 32'h00000000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PARITY_BIT  = 31;
  localparam int SEQ_OFF_BIT = 24;
  localparam int CAP_BIT     = 23;
  localparam int VSEL_LSB    = 21;
  localparam int OFF_BIT     = 20;
  localparam int MINON_LSB   = 17;

  // ************************************************************
  // field codes
  // ************************************************************
  localparam logic [2:0] MINON_NONE = 3'h0;
  localparam logic [2:0] MINON_AUTO = 3'h1;
  localparam logic [1:0] VSEL_3V3   = 2'h0;
  localparam logic [1:0] VSEL_5V0   = 2'h1;
  localparam logic [1:0] VSEL_4V0   = 2'h2;
  localparam logic [1:0] VSEL_5V7   = 2'h3;

  // ************************************************************
  // timing: times in ns, counts rounded up at the clock rate
  // ************************************************************
  localparam int CLK_MHZ     = 250;
  localparam int MINON_A_NS  = 500;
  localparam int MINON_B_NS  = 750;
  localparam int MINON_C_NS  = 1000;
  localparam int MINON_D_NS  = 1250;
  localparam int MINON_E_NS  = 1500;
  localparam int MINON_F_NS  = 2000;
  localparam int AUTO_S0_NS  = 2000;
  localparam int AUTO_S1_NS  = 1000;
  localparam int AUTO_S2_NS  = 750;
  localparam int AUTO_S3_NS  = 500;

  localparam logic [9:0] MINON_A_CYC = 10'((MINON_A_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] MINON_B_CYC = 10'((MINON_B_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] MINON_C_CYC = 10'((MINON_C_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] MINON_D_CYC = 10'((MINON_D_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] MINON_E_CYC = 10'((MINON_E_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] MINON_F_CYC = 10'((MINON_F_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] AUTO_S0_CYC = 10'((AUTO_S0_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] AUTO_S1_CYC = 10'((AUTO_S1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] AUTO_S2_CYC = 10'((AUTO_S2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] AUTO_S3_CYC = 10'((AUTO_S3_NS * CLK_MHZ + 999) / 1000);

  // minimum on-time in cycles for a field code and slew setting
  function automatic logic [9:0] dscr_minon_cyc(input logic [2:0] code,
                                                input logic [1:0] slew);
    logic [9:0] cyc;
    cyc = 10'h000;
    unique case (code)
      3'h0: cyc = 10'h000;
      3'h1: begin
        unique case (slew)
          2'h0: cyc = AUTO_S0_CYC;
          2'h1: cyc = AUTO_S1_CYC;
          2'h2: cyc = AUTO_S2_CYC;
          2'h3: cyc = AUTO_S3_CYC;
        endcase
      end
      3'h2: cyc = MINON_A_CYC;
      3'h3: cyc = MINON_B_CYC;
      3'h4: cyc = MINON_C_CYC;
      3'h5: cyc = MINON_D_CYC;
      3'h6: cyc = MINON_E_CYC;
      3'h7: cyc = MINON_F_CYC;
    endcase
    return cyc;
  endfunction : dscr_minon_cyc

  // remaining count loaded when the switch turns on
  function automatic logic [9:0] dscr_minon_load(input logic [2:0] code,
                                                 input logic [1:0] slew);
    logic [9:0] cyc;
    cyc = dscr_minon_cyc(code, slew);
    return (cyc == 10'h000) ? 10'h000 : cyc - 10'h001;
  endfunction : dscr_minon_load

endpackage : dscr_pkg

/* dscr_minon_if.sv */
// carrier of the on-time code from the register and the slew setting from the slew_code input to the low-side timer
`timescale 1ns/1ps
interface dscr_minon_if;
  logic [2:0] code;
  logic [1:0] slew;
  modport src  (output code, output slew);
  modport sink (input code, input slew);
endinterface : dscr_minon_if

/* dscr_minon.sv */
// low-side switch minimum on-time enforcer
`timescale 1ns/1ps
module dscr_minon (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // settings
  dscr_minon_if.sink       cfg,
  // gate request and result
  input  wire logic        ls_req,
  output logic             ls_on
);
  import dscr_pkg::*;

  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic       next_on;

  // ************************************************************
  // on-time timer
  // ************************************************************
  always_comb begin
    next_on  = ls_on;
    next_cnt = cnt;
    if (!ls_on) begin
      if (ls_req) begin
        next_on  = 1'b1;
        next_cnt = dscr_minon_load(cfg.code, cfg.slew);
      end
    end else begin
      next_on  = ls_req || (cnt != 10'h000);
      next_cnt = (cnt != 10'h000) ? cnt - 10'h001 : 10'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ls_on <= 1'b0;
      cnt   <= 10'h000;
    end else begin
      ls_on <= next_on;
      cnt   <= next_cnt;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_minon_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ls_on && (cnt != 10'h000) |=> ls_on)
    else $error("low-side switch released before its minimum on-time");

  chk_minon_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ls_on) && ($past(cfg.code) == 3'h4) |-> cnt == MINON_C_CYC - 10'h001)
    else $error("fixed minimum on-time loaded wrong count");

  chk_minon_auto: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ls_on) && ($past(cfg.code) == MINON_AUTO)
      |-> cnt == dscr_minon_load(MINON_AUTO, $past(cfg.slew)))
    else $error("automatic minimum on-time not taken from slew setting");

  chk_minon_none: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ls_on) && ($past(cfg.code) == MINON_NONE) |-> cnt == 10'h000)
    else $error("zero minimum on-time still loaded a count");

endmodule : dscr_minon

/* dscr_top.sv */
// supply and gate-driver configuration register with wishbone slave
`timescale 1ns/1ps
module dscr_top (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [dscr_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic                            wb_ack_o,
  output logic      [31:0]                wb_dat_o,
  // regulator controls
  output logic                            regulator_sequencing_off,
  output logic                            regulator_current_cap,
  output logic      [1:0]                 regulator_vsel,
  output logic                            regulator_off,
  // low-side switch
  input  wire logic [1:0]                 slew_code,
  input  wire logic                       ls_req,
  output logic                            ls_on
);
  import dscr_pkg::*;

  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        req;
  logic        hit;
  logic [31:0] lane_mask;

  dscr_minon_if minon_bus ();

  // ************************************************************
  // bus decode
  // ************************************************************
  assign req = wb_cyc_i && wb_stb_i;
  assign hit = (wb_adr_i == CFG_ADDR);

  always_comb begin
    lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  // ************************************************************
  // register and bus answer
  // ************************************************************
  always_comb begin
    next_cfg = cfg;
    next_ack = req && !wb_ack_o;
    next_dat = wb_dat_o;
    // write lands on the edge where ack is seen high
    if (req && wb_ack_o && wb_we_i && hit) begin
      next_cfg = (cfg & ~(CFG_WMASK & lane_mask))
               | (wb_dat_i & CFG_WMASK & lane_mask);
    end
    if (req && !wb_ack_o) begin
      next_dat = (hit && !wb_we_i) ? (cfg & CFG_WMASK) : UNMAP_DATA;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg      <= CFG_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      cfg      <= next_cfg;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ************************************************************
  // field outputs
  // ************************************************************
  assign regulator_sequencing_off = cfg[SEQ_OFF_BIT];
  assign regulator_current_cap    = cfg[CAP_BIT];
  assign regulator_vsel           = cfg[VSEL_LSB +: 2];
  assign regulator_off            = cfg[OFF_BIT];

  assign minon_bus.code = cfg[MINON_LSB +: 3];
  assign minon_bus.slew = slew_code;

  dscr_minon u_minon (
    .clk    (clk),
    .rst_n  (rst_n),
    .cfg    (minon_bus.sink),
    .ls_req (ls_req),
    .ls_on  (ls_on)
  );

  // ************************************************************
  // checks
  // ************************************************************
  chk_reset_clear: assert property (@(posedge clk)
    !rst_n |=> (cfg == CFG_RESET) && !wb_ack_o)
    else $error("register not cleared by reset");

  chk_seq_write: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_ack_o && wb_we_i && hit && wb_sel_i[3]
      |=> regulator_sequencing_off == $past(wb_dat_i[SEQ_OFF_BIT]))
    else $error("sequencing disable bit did not take written value");

  chk_cap_write: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_ack_o && wb_we_i && hit && wb_sel_i[2]
      |=> regulator_current_cap == $past(wb_dat_i[CAP_BIT]))
    else $error("current limit select did not take written value");

  chk_vsel_write: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_ack_o && wb_we_i && hit && wb_sel_i[2]
      |=> regulator_vsel == $past(wb_dat_i[22:21]))
    else $error("voltage select did not take written value");

  chk_off_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !(req && wb_ack_o && wb_we_i && hit) |=> $stable(regulator_off))
    else $error("regulator disable changed without a write");

  chk_minon_field: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_ack_o && wb_we_i && hit && wb_sel_i[2]
      |=> minon_bus.code == $past(wb_dat_i[19:17]))
    else $error("minimum on-time field did not take written value");

  chk_auto_slew: assert property (@(posedge clk) disable iff (!rst_n)
    ls_req && !ls_on && (minon_bus.code == MINON_AUTO)
      |=> ls_on [*8])
    else $error("automatic on-time released too early");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |-> ((wb_dat_o & ~CFG_WMASK) == 32'h00000000)
              && ((cfg & ~CFG_WMASK) == 32'h00000000))
    else $error("reserved bits not zero");

  chk_parity_keep: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_ack_o && wb_we_i && hit && wb_sel_i[3]
      |=> cfg[PARITY_BIT] == $past(wb_dat_i[PARITY_BIT]))
    else $error("parity bit not writable");

  chk_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle one edge after request");

  chk_ack_reset: assert property (@(posedge clk)
    !rst_n
      |=> !wb_ack_o && (wb_dat_o == 32'h00000000))
    else $error("bus answer not cleared by reset");

  chk_fields_reset: assert property (@(posedge clk)
    !rst_n
      |=> !regulator_sequencing_off && !regulator_current_cap && (regulator_vsel == 2'h0))
    else $error("regulator controls not cleared by reset");

  chk_unmap_write: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_ack_o && wb_we_i && !hit
      |=> $stable(cfg))
    else $error("write to an unmapped address changed the register");

  chk_unmap_read: assert property (@(posedge clk) disable iff (!rst_n)
    req && !wb_ack_o && !wb_we_i && !hit
      |=> wb_dat_o == UNMAP_DATA)
    else $error("read of an unmapped address returned data");

  chk_read_data: assert property (@(posedge clk) disable iff (!rst_n)
    req && !wb_ack_o && !wb_we_i && hit
      |=> wb_dat_o == ($past(cfg) & CFG_WMASK))
    else $error("register read returned wrong data");

  chk_seq_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !(req && wb_ack_o && wb_we_i && hit && wb_sel_i[3])
      |=> $stable(regulator_sequencing_off))
    else $error("sequencing disable changed without a write");

  chk_cap_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !(req && wb_ack_o && wb_we_i && hit && wb_sel_i[2])
      |=> $stable(regulator_current_cap))
    else $error("current limit select changed without a write");

  chk_vsel_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !(req && wb_ack_o && wb_we_i && hit && wb_sel_i[2])
      |=> $stable(regulator_vsel))
    else $error("voltage select changed without a write");

  chk_off_write: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_ack_o && wb_we_i && hit && wb_sel_i[2]
      |=> regulator_off == $past(wb_dat_i[OFF_BIT]))
    else $error("regulator disable did not take written value");

  chk_minon_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !(req && wb_ack_o && wb_we_i && hit && wb_sel_i[2])
      |=> $stable(minon_bus.code))
    else $error("minimum on-time field changed without a write");

  chk_parity_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !(req && wb_ack_o && wb_we_i && hit && wb_sel_i[3])
      |=> $stable(cfg[PARITY_BIT]))
    else $error("parity bit changed without a write");

  chk_low_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    req && wb_ack_o && wb_we_i && hit && (wb_sel_i[3:2] == 2'h0)
      |=> $stable(cfg))
    else $error("write to reserved lanes changed the register");

  chk_dat_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(req && !wb_ack_o)
      |=> $stable(wb_dat_o))
    else $error("read data changed without a request");

  chk_ack_needs_req: assert property (@(posedge clk) disable iff (!rst_n)
    !req
      |=> !wb_ack_o)
    else $error("ack given without a request");

endmodule : dscr_top

/* tb_top.sv */
// self-checking bench for the driver supply configuration register
`timescale 1ns/1ps
module tb_top;
  import dscr_pkg::*;

  // ************************************************************
  // signals
  // ************************************************************
  logic              clk      = 1'b0;
  logic              rst_n    = 1'b0;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i  = 1'b0;
  logic [ADR_W-1:0]  wb_adr_i = '0;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h00000000;
  logic              wb_ack_o;
  logic [31:0]       wb_dat_o;
  logic              seq_off;
  logic              cap;
  logic [1:0]        vsel;
  logic              reg_off;
  logic [1:0]        slew_code = 2'h0;
  logic              ls_req    = 1'b0;
  logic              ls_on;
  int                n_errors  = 0;
  int                cmp_count = 0;
  int                on_ns[8]   = '{0, 2000, 500, 750, 1000, 1250, 1500, 2000};
  int                auto_ns[4] = '{2000, 1000, 750, 500};

  always #2 clk = ~clk;

  dscr_top dut_u (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .wb_cyc_i                 (wb_cyc_i),
    .wb_stb_i                 (wb_stb_i),
    .wb_we_i                  (wb_we_i),
    .wb_adr_i                 (wb_adr_i),
    .wb_sel_i                 (wb_sel_i),
    .wb_dat_i                 (wb_dat_i),
    .wb_ack_o                 (wb_ack_o),
    .wb_dat_o                 (wb_dat_o),
    .regulator_sequencing_off (seq_off),
    .regulator_current_cap    (cap),
    .regulator_vsel           (vsel),
    .regulator_off            (reg_off),
    .slew_code                (slew_code),
    .ls_req                   (ls_req),
    .ls_on                    (ls_on)
  );

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_errors++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask : wb_xfer

  task automatic wr(input logic [ADR_W-1:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    logic [31:0] d;
    wb_xfer(1'b1, adr, sel, dat, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [ADR_W-1:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb_xfer(1'b0, adr, 4'hF, 32'h00000000, d);
    chk(name, d, exp);
  endtask : rd_chk

  // single-cycle request, then count how long the switch stays on
  task automatic pulse(input logic [2:0] code, input logic [1:0] slew, input int exp_n);
    int n;
    n = 0;
    wr(CFG_ADDR, 4'h4, {12'h000, code, 17'h00000});
    slew_code <= slew;
    @(posedge clk);
    ls_req <= 1'b1;
    repeat (600) begin
      @(posedge clk);
      ls_req <= 1'b0;
      #1;
      if (ls_on === 1'b1) n++;
    end
    chk("ls_on cycles", 32'(n), 32'(exp_n));
  endtask : pulse

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("outputs at reset", {27'h0, seq_off, cap, vsel, reg_off}, 32'h0);
    rd_chk("cfg reset", CFG_ADDR, 32'h00000000);
    wr(CFG_ADDR, 4'hF, 32'hFFFFFFFF);
    rd_chk("cfg all ones", CFG_ADDR, 32'h81FE0000);
    chk("outputs all ones", {27'h0, seq_off, cap, vsel, reg_off}, 32'h1F);
    wr(CFG_ADDR, 4'h8, 32'h00000000);
    rd_chk("cfg byte lane", CFG_ADDR, 32'h00FE0000);
    wr(12'h2BC, 4'hF, 32'h00000000);
    rd_chk("cfg after unmapped", CFG_ADDR, 32'h00FE0000);
    rd_chk("unmapped read", 12'h2BC, 32'h00000000);
    for (int i = 0; i < 5; i++) begin
      wr(CFG_ADDR, 4'hF, 32'h1 << (20 + i));
      #1;
      chk("regulator outputs", {27'h0, seq_off, cap, vsel, reg_off}, 32'h1 << i);
    end
    for (int c = 0; c < 8; c++) begin
      pulse(3'(c), 2'h0, (c == 0) ? 1 : (on_ns[c] + 3) / 4);
    end
    for (int s = 0; s < 4; s++) begin
      pulse(3'h1, 2'(s), (auto_ns[s] + 3) / 4);
    end
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule : tb_top
